// >>> hdl/ccc_pkg.sv
// Constants for the channel calibration and configuration register bank.
// Assumes a 32-bit AXI4-Lite register bus with each register in one aligned word.
package ccc_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_CH4_SETUP = 6'h1D;
  localparam logic [5:0] IDX_CH4_OFS_HI = 6'h1E;
  localparam logic [5:0] IDX_CH4_OFS_LO = 6'h1F;
  localparam logic [5:0] IDX_CH4_GAIN_HI = 6'h20;
  localparam logic [5:0] IDX_CH4_GAIN_LO = 6'h21;
  localparam logic [5:0] IDX_CH5_SETUP = 6'h22;
  localparam int IDX_LSB = 2;
  localparam int MIN_ADDR_W = 8;

  // ----------------------------------------------------------------------
  // Reset values and field layout.
  // ----------------------------------------------------------------------
  localparam logic [15:0] SETUP_RST = 16'h0000;
  localparam logic [15:0] OFS_HI_RST = 16'h0000;
  localparam logic [7:0] OFS_LO_RST = 8'h00;
  localparam logic [15:0] GAIN_HI_RST = 16'h8000;
  localparam logic [7:0] GAIN_LO_RST = 8'h00;
  localparam logic [15:0] SETUP_WMASK = 16'hFFC7;
  localparam int PHASE_MSB = 15;
  localparam int PHASE_LSB = 6;
  localparam int BYPASS_BIT = 2;
  localparam int SEL_MSB = 1;
  localparam int SEL_LSB = 0;
  localparam logic [1:0] SEL_PINS = 2'b00;
  localparam logic [1:0] SEL_SHORTED = 2'b01;
  localparam logic [1:0] SEL_TEST_POS = 2'b10;
  localparam logic [1:0] SEL_TEST_NEG = 2'b11;
  localparam logic [3:0] CORNER_OFF = 4'h0;

  // ----------------------------------------------------------------------
  // Bus answers and datapath scaling.
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [15:0] RDATA_PAD = 16'h0000;
  localparam int GAIN_FRAC = 23;
  localparam logic [23:0] SAT_POS = 24'h7F_FFFF;
  localparam logic [23:0] SAT_NEG = 24'h80_0000;
  localparam logic [23:0] GAIN_UNITY = 24'h80_0000;

endpackage : ccc_pkg

// >>> hdl/ccc_regs.sv
// Register bank for one converter channel: setup, offset and gain calibration,
// plus the next channel's setup word, with the calibration applied to samples.
// Assumes an AXI4-Lite master on the same clock and samples synchronous to it.
//
// Overview of operation
// - Setup bits 15:6 hold a signed phase shift in modulator cycles, reset zero.
// - Bypass bit 2 clear, the default, lets the global corner setting steer filtering.
// - Bypass bit set disables this channel's DC-block filter regardless of global setting.
// - Selector bits 1:0 pick pins, shorted inputs, positive or negative test signal.
// - Offset high register holds offset bits 23:8 in all sixteen bits, reset zero.
// - Offset low register holds offset bits 7:0 in its upper byte; low byte reserved.
// - Gain high register holds gain bits 23:8, resetting to 8000h for unity gain.
// - Gain low register holds gain bits 7:0 in its upper byte; low byte reserved.
// - Gain is an unsigned fraction from zero to just under two.
// - Registers sit at indices 1Dh to 21h, next channel setup at 22h.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module ccc_regs import ccc_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [3:0] highpass_corner_select_i,
  input wire logic [23:0] sample_i,
  input wire logic sample_valid_i,
  output logic [9:0] ch4_phase_shift_o,
  output logic ch4_highpass_bypass_o,
  output logic [3:0] ch4_highpass_corner_o,
  output logic [1:0] ch4_input_selector_o,
  output logic [23:0] ch4_offset_o,
  output logic [23:0] ch4_gain_o,
  output logic [15:0] ch5_setup_o,
  output logic [23:0] corr_data_o,
  output logic corr_valid_o
);

  // ----------------------------------------------------------------------
  // Elaboration check.
  // ----------------------------------------------------------------------
  if (ADDR_W < MIN_ADDR_W) begin : g_addr_check
    $error("ADDR_W too small to reach the register map");
  end

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic [15:0] setup4;
    logic [15:0] ofs_hi;
    logic [7:0] ofs_lo;
    logic [15:0] gain_hi;
    logic [7:0] gain_lo;
    logic [15:0] setup5;
    logic [3:0] corner4;
    logic corr_valid;
    logic [23:0] corr_data;
  } ccc_state_s;

  ccc_state_s s_reg;
  ccc_state_s s_next;

  // Reading a register: hit flag above sixteen data bits; reserved bits are zero.
  function automatic logic [16:0] ccc_read(input ccc_state_s st, input logic [5:0] idx);
    logic [16:0] r;
    r = {1'b0, RDATA_PAD};
    if (idx == IDX_CH4_SETUP) begin
      r = {1'b1, st.setup4};
    end else if (idx == IDX_CH4_OFS_HI) begin
      r = {1'b1, st.ofs_hi};
    end else if (idx == IDX_CH4_OFS_LO) begin
      r = {1'b1, st.ofs_lo, 8'h00};
    end else if (idx == IDX_CH4_GAIN_HI) begin
      r = {1'b1, st.gain_hi};
    end else if (idx == IDX_CH4_GAIN_LO) begin
      r = {1'b1, st.gain_lo, 8'h00};
    end else if (idx == IDX_CH5_SETUP) begin
      r = {1'b1, st.setup5};
    end
    return r;
  endfunction : ccc_read

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  logic aw_go;
  logic w_go;
  logic [5:0] widx;
  logic [15:0] wd;
  logic [1:0] ws;
  logic [16:0] old;
  logic [15:0] merged;
  logic [16:0] rd;
  logic signed [24:0] sum;
  logic signed [49:0] prod;

  always_comb begin
    s_next = s_reg;
    s_next.corr_valid = 1'b0;
    aw_go = s_axi_awvalid_i && s_reg.awready;
    w_go = s_axi_wvalid_i && s_reg.wready;
    widx = aw_go ? s_axi_awaddr_i[IDX_LSB +: 6] : s_reg.aw_idx;
    wd = w_go ? s_axi_wdata_i[15:0] : s_reg.wdata;
    ws = w_go ? s_axi_wstrb_i[1:0] : s_reg.wstrb;
    old = ccc_read(s_reg, widx);
    merged = {ws[1] ? wd[15:8] : old[15:8], ws[0] ? wd[7:0] : old[7:0]};
    rd = ccc_read(s_reg, s_axi_araddr_i[IDX_LSB +: 6]);
    sum = 25'(signed'({sample_i[23], sample_i}) + signed'({ch4_offset_o[23], ch4_offset_o}));
    prod = 50'(sum * signed'({1'b0, ch4_gain_o}));

    if (aw_go) begin
      s_next.aw_held = 1'b1;
      s_next.aw_idx = s_axi_awaddr_i[IDX_LSB +: 6];
    end
    if (w_go) begin
      s_next.w_held = 1'b1;
      s_next.wdata = s_axi_wdata_i[15:0];
      s_next.wstrb = s_axi_wstrb_i[1:0];
    end
    if (s_reg.bvalid && s_axi_bready_i) begin
      s_next.bvalid = 1'b0;
    end
    // Address and data may arrive in either order; the write lands once both are in.
    if ((s_reg.aw_held || aw_go) && (s_reg.w_held || w_go) && !s_reg.bvalid) begin
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = old[16] ? RESP_OKAY : RESP_SLVERR;
      if (widx == IDX_CH4_SETUP) begin
        s_next.setup4 = merged & SETUP_WMASK;
      end else if (widx == IDX_CH4_OFS_HI) begin
        s_next.ofs_hi = merged;
      end else if (widx == IDX_CH4_OFS_LO) begin
        s_next.ofs_lo = merged[15:8];
      end else if (widx == IDX_CH4_GAIN_HI) begin
        s_next.gain_hi = merged;
      end else if (widx == IDX_CH4_GAIN_LO) begin
        s_next.gain_lo = merged[15:8];
      end else if (widx == IDX_CH5_SETUP) begin
        s_next.setup5 = merged & SETUP_WMASK;
      end
    end
    s_next.awready = !s_next.aw_held && !s_next.bvalid;
    s_next.wready = !s_next.w_held && !s_next.bvalid;

    if (s_reg.rvalid && s_axi_rready_i) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = {RDATA_PAD, rd[15:0]};
      s_next.rresp = rd[16] ? RESP_OKAY : RESP_SLVERR;
    end
    s_next.arready = !s_next.rvalid;

    // A clear bypass passes the global corner on; a set one forces the filter off.
    s_next.corner4 = s_reg.setup4[BYPASS_BIT] ? CORNER_OFF : highpass_corner_select_i;

    // Offset first, then the gain fraction with 23 fractional bits, saturated.
    if (sample_valid_i) begin
      s_next.corr_valid = 1'b1;
      if (prod[49:46] == 4'h0 || prod[49:46] == 4'hF) begin
        s_next.corr_data = prod[GAIN_FRAC +: 24];
      end else begin
        s_next.corr_data = prod[49] ? SAT_NEG : SAT_POS;
      end
    end

    if (srst_i) begin
      s_next = '0;
      s_next.setup4 = SETUP_RST;
      s_next.ofs_hi = OFS_HI_RST;
      s_next.ofs_lo = OFS_LO_RST;
      s_next.gain_hi = GAIN_HI_RST;
      s_next.gain_lo = GAIN_LO_RST;
      s_next.setup5 = SETUP_RST;
    end
  end

  always_ff @(posedge clock_i) begin
    s_reg <= s_next;
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign s_axi_awready_o = s_reg.awready;
  assign s_axi_wready_o = s_reg.wready;
  assign s_axi_bresp_o = s_reg.bresp;
  assign s_axi_bvalid_o = s_reg.bvalid;
  assign s_axi_arready_o = s_reg.arready;
  assign s_axi_rdata_o = s_reg.rdata;
  assign s_axi_rresp_o = s_reg.rresp;
  assign s_axi_rvalid_o = s_reg.rvalid;
  assign ch4_phase_shift_o = s_reg.setup4[PHASE_MSB:PHASE_LSB];
  assign ch4_highpass_bypass_o = s_reg.setup4[BYPASS_BIT];
  assign ch4_highpass_corner_o = s_reg.corner4;
  assign ch4_input_selector_o = s_reg.setup4[SEL_MSB:SEL_LSB];
  assign ch4_offset_o = {s_reg.ofs_hi, s_reg.ofs_lo};
  assign ch4_gain_o = {s_reg.gain_hi, s_reg.gain_lo};
  assign ch5_setup_o = s_reg.setup5;
  assign corr_data_o = s_reg.corr_data;
  assign corr_valid_o = s_reg.corr_valid;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking ccc_cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  logic wr_setup4;
  assign wr_setup4 = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && s_axi_awaddr_i[IDX_LSB +: 6] == IDX_CH4_SETUP && s_axi_wstrb_i[1:0] == 2'b11;

  a_phase_write: assert property (wr_setup4 |=> ch4_phase_shift_o == $past(s_axi_wdata_i[15:6]))
    else $error("phase shift did not take the written value");
  a_corner_follow: assert property (!ch4_highpass_bypass_o ##1 !srst_i
    |-> ch4_highpass_corner_o == $past(highpass_corner_select_i))
    else $error("corner does not follow the global setting");
  a_bypass_off: assert property (ch4_highpass_bypass_o |=> ch4_highpass_corner_o == CORNER_OFF)
    else $error("bypassed channel still filtered");
  a_selector_write: assert property (wr_setup4
    |=> ch4_input_selector_o == $past(s_axi_wdata_i[1:0]) ##1 $stable(ch4_input_selector_o)
    || $past(s_axi_awvalid_i))
    else $error("input selector wrong after write");
  a_offset_read: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[IDX_LSB +: 6] == IDX_CH4_OFS_HI
    |=> s_axi_rvalid_o && s_axi_rdata_o[15:0] == ch4_offset_o[23:8])
    else $error("offset high readback wrong");
  a_ofs_lo_res: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[IDX_LSB +: 6] == IDX_CH4_OFS_LO
    |=> s_axi_rdata_o[7:0] == 8'h00 && s_axi_rdata_o[15:8] == ch4_offset_o[7:0])
    else $error("offset low readback wrong");
  a_gain_reset: assert property ($fell(srst_i) |-> ch4_gain_o == GAIN_UNITY)
    else $error("gain not unity after reset");
  a_gain_lo_res: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[IDX_LSB +: 6] == IDX_CH4_GAIN_LO
    |=> s_axi_rdata_o[7:0] == 8'h00 && s_axi_rdata_o[15:8] == ch4_gain_o[7:0])
    else $error("gain low readback wrong");
  a_unity_pass: assert property (sample_valid_i && ch4_gain_o == GAIN_UNITY
    && ch4_offset_o == 24'h00_0000 |=> corr_valid_o && corr_data_o == $past(sample_i))
    else $error("unity gain altered the sample");
  a_unmapped_err: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[IDX_LSB +: 6] > IDX_CH5_SETUP
    |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_reserved_zero: assert property (s_reg.setup4[5:3] == 3'b000
    && s_reg.setup5[5:3] == 3'b000)
    else $error("reserved setup bits set");
  a_offset_apply: assert property (sample_valid_i && ch4_gain_o == GAIN_UNITY
    && sample_i == 24'h00_0000 && !ch4_offset_o[23]
    |=> corr_data_o == $past(ch4_offset_o))
    else $error("offset word not applied");

  // ----------------------------------------------------------------------
  // Bus handshake and hold checks.
  // ----------------------------------------------------------------------
  // Readies drop for the whole transaction, so a second request waits for the answer.
  // That costs one idle cycle per access but needs no request queue.
  logic wr_ch5;
  assign wr_ch5 = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && s_axi_awaddr_i[IDX_LSB +: 6] == IDX_CH5_SETUP && s_axi_wstrb_i[1:0] == 2'b11;
  logic wr_gain_hi;
  assign wr_gain_hi = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    && s_axi_awaddr_i[IDX_LSB +: 6] == IDX_CH4_GAIN_HI && s_axi_wstrb_i[1:0] == 2'b11;

  a_aw_block: assert property (s_axi_awvalid_i && s_axi_awready_o
    |=> !s_axi_awready_o)
    else $error("write address ready stayed high after a transfer");
  a_w_block: assert property (s_axi_wvalid_i && s_axi_wready_o
    |=> !s_axi_wready_o)
    else $error("write data ready stayed high after a transfer");
  a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped before it was taken");
  a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
    else $error("read answer changed before it was taken");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read answer not given one cycle after the address");
  a_b_rise: assert property ($rose(s_axi_bvalid_o)
    |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write readies high as the response rose");
  a_ar_wait: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address ready high while an answer waits");
  a_aw_wait: assert property (s_axi_bvalid_o
    |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write readies high while a response waits");

  // ----------------------------------------------------------------------
  // Field and datapath checks.
  // ----------------------------------------------------------------------
  // Write checks cover full-strobe writes only; partial writes are left to the bench.
  a_ch5_write: assert property (wr_ch5
    |=> ch5_setup_o == ($past(s_axi_wdata_i[15:0]) & SETUP_WMASK))
    else $error("next channel setup did not take the written value");
  a_gain_hi_write: assert property (wr_gain_hi
    |=> ch4_gain_o[23:8] == $past(s_axi_wdata_i[15:0]))
    else $error("gain high did not take the written value");
  a_low_unmapped: assert property (s_axi_arvalid_i && s_axi_arready_o
    && s_axi_araddr_i[IDX_LSB +: 6] < IDX_CH4_SETUP
    |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("read below the map not refused");
  a_bypass_out: assert property (wr_setup4
    |=> ch4_highpass_bypass_o == $past(s_axi_wdata_i[BYPASS_BIT]))
    else $error("bypass bit did not take the written value");
  a_rdata_pad: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == RDATA_PAD)
    else $error("upper read data bits not zero");
  // Saturation itself is left to the bench's reference model.
  a_corr_quiet: assert property (!sample_valid_i |=> !corr_valid_o)
    else $error("corrected sample without an input sample");
  a_corr_answer: assert property (sample_valid_i |=> corr_valid_o)
    else $error("corrected sample missing one cycle after input");

endmodule : ccc_regs

// >>> verification/tb_ccc_regs.sv
// Self-checking bench for the channel calibration register bank.
// Assumes the bank answers one AXI4-Lite write and one read at a time on clock_i.
`timescale 1ns/1ns
module tb_ccc_regs import ccc_pkg::*; ;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, sample_valid_i = 0;
  logic [31:0] s_axi_wdata_i = '0;
  logic [3:0] s_axi_wstrb_i = '0, highpass_corner_select_i = '0;
  logic [23:0] sample_i = '0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, ch4_input_selector_o;
  logic [31:0] s_axi_rdata_o;
  logic [9:0] ch4_phase_shift_o;
  logic ch4_highpass_bypass_o, corr_valid_o;
  logic [3:0] ch4_highpass_corner_o;
  logic [23:0] ch4_offset_o, ch4_gain_o, corr_data_o;
  logic [15:0] ch5_setup_o;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [23:0] sq[$];
  logic [31:0] seed = 32'h0000_8b2b;
  int fails = 0, check_count = 0, cycles = 0;

  ccc_regs i_ccc_regs (.clock_i, .srst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .highpass_corner_select_i, .sample_i, .sample_valid_i, .ch4_phase_shift_o,
    .ch4_highpass_bypass_o, .ch4_highpass_corner_o, .ch4_input_selector_o, .ch4_offset_o,
    .ch4_gain_o, .ch5_setup_o, .corr_data_o, .corr_valid_o);

  always #25 clock_i = ~clock_i;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Reference calibration: signed sum, unsigned gain, arithmetic shift, then saturate.
  function automatic logic [23:0] cal(input logic [23:0] s, o, g);
    longint t;
    t = (longint'($signed(s)) + longint'($signed(o))) * longint'(g);
    t = t >>> 23;
    if (t > 64'sd8388607) return SAT_POS;
    if (t < -64'sd8388608) return SAT_NEG;
    return t[23:0];
  endfunction : cal

  task automatic chk(input string what, input logic [33:0] e, g);
    check_count++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] st,
                    input logic [1:0] rs);
    bq.push_back(rs);
    s_axi_awaddr_i <= {idx, 2'b00};
    s_axi_wdata_i <= {16'h0000, d};
    s_axi_wstrb_i <= st;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awvalid_i && s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    // One idle edge keeps the next call from re-raising bready in the same step.
    @(posedge clock_i);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] rs);
    rq.push_back({rs, 16'h0000, d});
    s_axi_araddr_i <= {idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arvalid_i && s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    @(posedge clock_i);
  endtask : rd

  // ----------------------------------------------------------------------
  // Output watcher and hang guard
  // ----------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) chk("read", rq.pop_front(),
        {s_axi_rresp_o, s_axi_rdata_o});
    if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i) chk("bresp", bq.pop_front(), s_axi_bresp_o);
    if (corr_valid_o === 1'b1) chk("corr", sq.pop_front(), corr_data_o);
    cycles++;
    if (cycles > 6000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] v;
    logic [23:0] o, g, s;
    logic [3:0] c;
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rd(IDX_CH4_SETUP, SETUP_RST, RESP_OKAY);
    rd(IDX_CH4_OFS_HI, 16'h0000, RESP_OKAY);
    rd(IDX_CH4_OFS_LO, 16'h0000, RESP_OKAY);
    rd(IDX_CH4_GAIN_HI, 16'h8000, RESP_OKAY);
    rd(IDX_CH4_GAIN_LO, 16'h0000, RESP_OKAY);
    rd(IDX_CH5_SETUP, 16'h0000, RESP_OKAY);
    rd(6'h3F, 16'h0000, RESP_SLVERR);
    chk("gain", 24'h80_0000, ch4_gain_o);
    $display("test reset values done");
    wr(IDX_CH4_SETUP, 16'hFFFF, 4'hF, RESP_OKAY);
    rd(IDX_CH4_SETUP, 16'hFFC7, RESP_OKAY);
    chk("phase", 10'h3FF, ch4_phase_shift_o);
    wr(IDX_CH4_OFS_LO, 16'hFFFF, 4'hF, RESP_OKAY);
    rd(IDX_CH4_OFS_LO, 16'hFF00, RESP_OKAY);
    wr(IDX_CH4_GAIN_LO, 16'hFFFF, 4'hF, RESP_OKAY);
    rd(IDX_CH4_GAIN_LO, 16'hFF00, RESP_OKAY);
    wr(6'h3F, 16'h1234, 4'hF, RESP_SLVERR);
    wr(IDX_CH4_GAIN_HI, 16'h1234, 4'h2, RESP_OKAY);
    rd(IDX_CH4_GAIN_HI, 16'h1200, RESP_OKAY);
    v = rnd();
    wr(IDX_CH5_SETUP, v, 4'hF, RESP_OKAY);
    rd(IDX_CH5_SETUP, v & SETUP_WMASK, RESP_OKAY);
    chk("ch5", v & SETUP_WMASK, ch5_setup_o);
    $display("test field access done");
    for (int i = 0; i < 8; i++) begin
      v = {rnd() & 16'hFFC0} | 16'(i[2:0]);
      c = rnd();
      highpass_corner_select_i <= c;
      wr(IDX_CH4_SETUP, v, 4'hF, RESP_OKAY);
      repeat (2) @(posedge clock_i);
      chk("corner", i[2] ? CORNER_OFF : c, ch4_highpass_corner_o);
      chk("select", i[1:0], ch4_input_selector_o);
      chk("bypass", i[2], ch4_highpass_bypass_o);
      chk("phase", v[15:6], ch4_phase_shift_o);
    end
    $display("test setup fields done");
    for (int k = 0; k < 4; k++) begin
      o = rnd();
      g = (k == 0) ? GAIN_UNITY : rnd();
      wr(IDX_CH4_OFS_HI, o[23:8], 4'hF, RESP_OKAY);
      wr(IDX_CH4_OFS_LO, {o[7:0], 8'h00}, 4'hF, RESP_OKAY);
      wr(IDX_CH4_GAIN_HI, g[23:8], 4'hF, RESP_OKAY);
      wr(IDX_CH4_GAIN_LO, {g[7:0], 8'h00}, 4'hF, RESP_OKAY);
      chk("offset", o, ch4_offset_o);
      chk("gain", g, ch4_gain_o);
      for (int n = 0; n < 4; n++) begin
        s = rnd();
        sample_i <= s;
        sample_valid_i <= 1'b1;
        sq.push_back(cal(s, o, g));
        @(posedge clock_i);
      end
      sample_valid_i <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
    $display("test calibration done");
    end_of_test();
  end
endmodule : tb_ccc_regs
